// ==== apb_decode.sv ====
/*
  Address decode and refusal logic for the APB slave.
  Assumes a synchronous APB master and the busy flag of the shifter.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pll_consts.svh"

module apb_decode import pll_types_pkg::*; (
  input wire apb_req_t req,
  input wire logic busy,
  output logic setup,
  output logic access,
  output logic hit_ctrl,
  output logic hit_stat,
  output logic err,
  output logic wr_ctrl,
  output logic wr_clk0
);

  wire logic hit_clk0;
  wire logic mapped;
  wire logic narrow;
  wire logic blocked;

  assign setup = req.psel & ~req.penable;
  assign access = req.psel & req.penable;
  assign hit_ctrl = req.paddr == `CTRL_OFF;
  assign hit_stat = req.paddr == `STAT_OFF;
  assign hit_clk0 = req.paddr == `CLK0_OFF;
  assign mapped = hit_ctrl | hit_stat | hit_clk0;
  // Partial-lane writes are refused
  assign narrow = req.pwrite & (req.pstrb != `FULL_STROBE); // RQ1
  // A divider write during a running transfer is refused
  assign blocked = req.pwrite & hit_ctrl & busy; // RQ13
  assign err = access & (~mapped | narrow | blocked);
  assign wr_ctrl = access & req.pwrite & hit_ctrl & ~narrow & ~busy;
  assign wr_clk0 = access & req.pwrite & hit_clk0 & ~narrow;

endmodule // apb_decode

`default_nettype wire

// ==== pll_consts.svh ====
/*
  Offsets, field positions, reset values and timing counts for the
  divider shadow register block.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef PLL_CONSTS_SVH
`define PLL_CONSTS_SVH

`define ADDR_W 16
`define CTRL_OFF 16'h8130
`define STAT_OFF 16'h8110
`define CLK0_OFF 16'h8114

`define STAT_BUSY_BIT 0
`define CLK0_SOFT_CLR_BIT 31

`define TARGET_ID 4'hF
`define UNUSED_RST 4'h0
`define FEEDBACK_RST 18'h002F8
`define POST_DIV_RST 4'h2
`define PUMP_GAIN_RST 2'h0
`define CTRL_RST 32'h0802F80F

`define FULL_STROBE 4'hF
`define SER_BITS 6'd32
`define SER_LAST 6'd31
`define SER_DIV 8'd4

`endif

// ==== pll_divider_shadow_register.sv ====
/*
  Divider shadow register: APB slave holding the feedback divider,
  post-divider and pump gain word, forwarded serially to the external
  clock chip on every accepted write, with a busy flag in status.
  Assumes por_n low at power-up only; rstn is the ordinary board reset.
*/
// Local design decision: register access over APB.
// Operation
// [RQ1] Register accepts only full 32-bit transfers; narrower writes are refused.
// [RQ2] Bits 3..0 always hold the target identifier 1111.
// [RQ3] Bits 25..8 hold the feedback divider, default 760.
// [RQ4] Host never programs a feedback divider of zero.
// [RQ5] Bits 29..26 hold the oscillator post-divider, default 0010.
// [RQ6] Host programs the post-divider only with values 2 to 8.
// [RQ7] Bits 31..30 select pump gain, default 00.
// [RQ8] Bits 7..4 are unused and read zero.
// [RQ9] Board reset keeps contents; power-up or soft-clear bit clears them.
// [RQ10] After power-up every bit is low except listed field defaults.
// [RQ11] Every accepted write starts a serial transfer of the word.
// [RQ12] Status bit 0 shows the serial transfer in progress.
// [RQ13] Host writes no other clock register until transfer completes.
// [RQ14] Host ensures the input clock runs before writing this register.
// [RQ15] Busy sets the cycle after the write, clears after load strobe.
`timescale 1ns/1ns
`default_nettype none
`include "pll_consts.svh"

module pll_divider_shadow_register import pll_types_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire apb_req_t apb_req,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic busy,
  output var ser_out_t ser
);

  ctrl_word_t ctrl_q;
  ctrl_word_t ctrl_d;
  ctrl_word_t ctrl_rst;
  logic [31:0] prdata_q;
  wire logic setup;
  wire logic access;
  wire logic hit_ctrl;
  wire logic hit_stat;
  wire logic err;
  wire logic wr_ctrl;
  wire logic wr_clk0;
  wire logic soft_clr;
  wire logic [31:0] rd_mux;
  wire logic [31:0] status_word;

  apb_decode u_decode (
    .req(apb_req),
    .busy(busy),
    .setup(setup),
    .access(access),
    .hit_ctrl(hit_ctrl),
    .hit_stat(hit_stat),
    .err(err),
    .wr_ctrl(wr_ctrl),
    .wr_clk0(wr_clk0)
  );

  // Zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = err;
  assign prdata = prdata_q;

  assign ctrl_rst = `CTRL_RST; // RQ10
  assign soft_clr = wr_clk0 & apb_req.pwdata[`CLK0_SOFT_CLR_BIT]; // RQ9

  // Identifier and unused bits are forced regardless of write data
  always_comb begin
    ctrl_d = apb_req.pwdata;
    ctrl_d.divider_control_target = `TARGET_ID; // RQ2
    ctrl_d.unused = `UNUSED_RST; // RQ8
  end

  // Only power-up or the soft-clear bit restores defaults
  always_ff @(posedge clk) begin
    if (!por_n || soft_clr) begin
      ctrl_q <= ctrl_rst; // RQ9
    end else if (wr_ctrl) begin
      ctrl_q <= ctrl_d; // RQ3 RQ5 RQ7
    end
  end

  assign status_word = {31'h00000000, busy}; // RQ12
  assign rd_mux = hit_ctrl ? ctrl_q : (hit_stat ? status_word : 32'h00000000);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      prdata_q <= rd_mux;
    end
  end

  serial_shifter u_shift (
    .clk(clk),
    .rstn(rstn),
    .start(wr_ctrl), // RQ11
    .word(ctrl_d),
    .busy(busy),
    .ser(ser)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence ctrl_write_s;
    wr_ctrl;
  endsequence

  sequence soft_clear_s;
    soft_clr && por_n;
  endsequence

  // Strobe stands one serial half-period; busy falls with it
  sequence strobe_pulse_s;
    (busy && ser.sle) [*4] ##1 (!busy && !ser.sle);
  endsequence

  property write_starts_busy_p;
    ctrl_write_s |=> busy;
  endproperty

  property loads_word_p;
    ctrl_write_s and (!soft_clr) |=>
      ctrl_q[31:8] == $past(apb_req.pwdata[31:8]);
  endproperty

  property clear_to_default_p;
    soft_clear_s |=> ctrl_q == `CTRL_RST;
  endproperty

  busy_set_a: assert property (write_starts_busy_p) // RQ15
    else $error("busy not set after divider write");

  word_load_a: assert property (loads_word_p) // RQ3
    else $error("divider fields not loaded from write data");

  soft_clear_a: assert property (clear_to_default_p) // RQ9
    else $error("soft clear did not restore defaults");

  target_bits_a: assert property (
    ctrl_q.divider_control_target == `TARGET_ID) // RQ2
    else $error("target identifier bits not all ones");

  unused_bits_a: assert property (ctrl_q.unused == `UNUSED_RST) // RQ8
    else $error("unused bits not zero");

  narrow_refused_a: assert property (
    access && apb_req.pwrite && apb_req.pstrb != `FULL_STROBE && por_n
    |-> pslverr ##1 $stable(ctrl_q)) // RQ1
    else $error("narrow write not refused");

  busy_refused_a: assert property (
    access && apb_req.pwrite && hit_ctrl && busy
    |-> pslverr && !wr_ctrl) // RQ13
    else $error("divider write accepted while busy");

  status_read_a: assert property (
    setup && hit_stat |=> prdata[0] == $past(busy) && prdata[31:1] == 31'h0)
    // RQ12
    else $error("status bit 0 does not show busy");

  busy_end_a: assert property (
    $fell(busy) |-> $past(ser.sle)) // RQ15
    else $error("busy cleared before load strobe");

  strobe_busy_a: assert property (
    $rose(ser.sle) |-> strobe_pulse_s) // RQ15
    else $error("load strobe outside busy period");

  por_default_a: assert property (
    disable iff (1'b0) !por_n |=> ctrl_q == `CTRL_RST) // RQ10
    else $error("power-up did not load defaults");

  board_keep_a: assert property (
    disable iff (1'b0) !rstn && por_n && !soft_clr && !wr_ctrl
    |=> $stable(ctrl_q)) // RQ9
    else $error("board reset disturbed divider register");

endmodule // pll_divider_shadow_register

`default_nettype wire

// ==== pll_divider_shadow_register_tb_top.sv ====
/*
  Self-checking bench for the divider shadow register block.
  Assumes the package, constants header, design and chip model.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pll_consts.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  num_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module pll_divider_shadow_register_tb_top import pll_types_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic por_n = 1'b0;
  apb_req_t req = '0;
  logic pready, pslverr, busy, err;
  logic [31:0] prdata, rd, rx_word;
  logic [7:0] rx_loads;
  ser_out_t ser;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  pll_divider_shadow_register u_dut (.clk(clk), .rstn(rstn),
    .por_n(por_n), .apb_req(req), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .busy(busy), .ser(ser));
  ser_chip_model u_chip (.ser(ser), .rx_word(rx_word),
    .rx_loads(rx_loads));

  task automatic apb(input logic wr, input logic [15:0] a,
      input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
      pwdata: d, pstrb: s};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n >= 20) begin
      num_errors++;
    end
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      n++;
      @(posedge clk);
    end
    if (n >= 400) begin
      num_errors++;
    end
  endtask

  task automatic t_defaults();
    apb(1'b0, `CTRL_OFF, 32'h0, `FULL_STROBE);
    `CHK("ctrl", `CTRL_RST, rd)
    `CHK("pready", 1'b1, pready)
    apb(1'b0, `STAT_OFF, 32'h0, `FULL_STROBE);
    `CHK("stat", 32'h0, rd)
  endtask

  task automatic t_write();
    // Nonzero feedback, post-divider 8, bench clock already running
    apb(1'b1, `CTRL_OFF, 32'hE0ABCD55, `FULL_STROBE);
    `CHK("wr err", 1'b0, err)
    @(negedge clk);
    `CHK("busy", 1'b1, busy)
    apb(1'b0, `STAT_OFF, 32'h0, `FULL_STROBE);
    `CHK("stat", 32'h1, rd)
    apb(1'b1, `CTRL_OFF, 32'h0800010F, `FULL_STROBE);
    `CHK("busy wr", 1'b1, err)
    apb(1'b0, `CTRL_OFF, 32'h0, `FULL_STROBE);
    `CHK("ctrl", 32'hE0ABCD0F, rd)
    wait_idle();
    `CHK("loads", 8'h01, rx_loads)
    `CHK("rx", 32'hE0ABCD0F, rx_word)
  endtask

  task automatic t_narrow();
    apb(1'b1, `CTRL_OFF, 32'h4C00100F, 4'h3);
    `CHK("narrow err", 1'b1, err)
    @(negedge clk);
    `CHK("narrow busy", 1'b0, busy)
    apb(1'b0, `CTRL_OFF, 32'h0, `FULL_STROBE);
    `CHK("narrow ctrl", 32'hE0ABCD0F, rd)
    apb(1'b0, 16'h8134, 32'h0, `FULL_STROBE);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped rd", 32'h0, rd)
  endtask

  task automatic t_resets();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, `CTRL_OFF, 32'h0, `FULL_STROBE);
    `CHK("board rst", 32'hE0ABCD0F, rd)
    apb(1'b1, `CLK0_OFF, 32'h7FFFFFFF, `FULL_STROBE);
    apb(1'b0, `CTRL_OFF, 32'h0, `FULL_STROBE);
    `CHK("no clear", 32'hE0ABCD0F, rd)
    apb(1'b1, `CLK0_OFF, 32'h80000000, `FULL_STROBE);
    apb(1'b0, `CTRL_OFF, 32'h0, `FULL_STROBE);
    `CHK("soft clear", `CTRL_RST, rd)
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    por_n <= 1'b1;
    t_defaults();
    t_write();
    t_narrow();
    t_resets();
    print_verdict();
  end
endmodule // pll_divider_shadow_register_tb_top

`default_nettype wire

// ==== pll_types_pkg.sv ====
/*
  Types shared by the divider shadow register block: bus request,
  register layout and serial output group.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package pll_types_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_t;

  typedef struct packed {
    logic [1:0] pump_gain_select;
    logic [3:0] oscillator_post_divider;
    logic [17:0] feedback_divider;
    logic [3:0] unused;
    logic [3:0] divider_control_target;
  } ctrl_word_t;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic sle;
  } ser_out_t;

  typedef enum logic [1:0] {
    SER_IDLE,
    SER_SHIFT,
    SER_LATCH
  } ser_state_t;

endpackage

`default_nettype wire

// ==== ser_chip_model.sv ====
/*
  Behavioural model of the external clock chip's serial programming port.
  Assumes sclk, sdata and sle come straight from the shadow register block.
*/
`timescale 1ns/1ns
`default_nettype none

module ser_chip_model import pll_types_pkg::*; (
  input wire ser_out_t ser,
  output logic [31:0] rx_word,
  output logic [7:0] rx_loads
);
  logic [31:0] shift_q;

  initial begin
    shift_q = 32'h0;
    rx_word = 32'h0;
    rx_loads = 8'h0;
  end

  // Data taken on rising serial clock, most significant bit first
  always @(posedge ser.sclk) shift_q <= {shift_q[30:0], ser.sdata};

  // Load strobe copies the shifted word into the target register
  always @(posedge ser.sle) begin
    rx_word <= shift_q;
    rx_loads <= rx_loads + 8'h01;
  end
endmodule // ser_chip_model

`default_nettype wire

// ==== serial_shifter.sv ====
/*
  Serial programming engine: shifts a 32-bit word MSB first to the
  external clock chip, then pulses its load strobe.
  Assumes start only while busy is low.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pll_consts.svh"

module serial_shifter import pll_types_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [31:0] word,
  output logic busy,
  output var ser_out_t ser
);

  ser_state_t state_q;
  logic [7:0] div_q;
  logic [31:0] shreg_q;
  logic [5:0] cnt_q;
  logic phase_q;
  logic sclk_q;
  logic sle_q;
  wire logic tick;

  // One-cycle enable every serial clock half-period, twice the serial bit rate
  assign tick = div_q == (`SER_DIV - 8'd1);
  assign busy = state_q != SER_IDLE;
  assign ser.sclk = sclk_q;
  assign ser.sdata = shreg_q[31];
  assign ser.sle = sle_q;

  always_ff @(posedge clk) begin
    if (!rstn || tick || state_q == SER_IDLE) begin
      div_q <= 8'd0;
    end else begin
      div_q <= div_q + 8'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= SER_IDLE;
      shreg_q <= 32'h00000000;
      cnt_q <= 6'd0;
      phase_q <= 1'b0;
      sclk_q <= 1'b0;
      sle_q <= 1'b0;
    end else begin
      unique case (state_q)
        SER_IDLE: begin
          if (start) begin
            state_q <= SER_SHIFT;
            shreg_q <= word;
            cnt_q <= 6'd0;
            phase_q <= 1'b0;
          end
        end
        SER_SHIFT: begin
          if (tick && !phase_q) begin
            sclk_q <= 1'b1;
            phase_q <= 1'b1;
          end else if (tick) begin
            sclk_q <= 1'b0;
            phase_q <= 1'b0;
            shreg_q <= {shreg_q[30:0], 1'b0};
            cnt_q <= cnt_q + 6'd1;
            if (cnt_q == `SER_LAST) begin
              state_q <= SER_LATCH;
            end
          end
        end
        SER_LATCH: begin
          // Busy clears only after the load strobe pulse
          if (tick && !sle_q) begin
            sle_q <= 1'b1;
          end else if (tick) begin
            sle_q <= 1'b0;
            state_q <= SER_IDLE; // RQ15
          end
        end
        default: begin
          state_q <= SER_IDLE;
        end
      endcase
    end
  end

endmodule // serial_shifter

`default_nettype wire
